// file: inc/dpo_defines.svh
// timing and field constants for the parallel output stage
`ifndef DPO_DEFINES_SVH
`define DPO_DEFINES_SVH
`define DPO_CLK_PERIOD_PS   5000
`define DPO_STAGGER_PS      1000
`define DPO_STAGGER_CYC \
  ((`DPO_STAGGER_PS + `DPO_CLK_PERIOD_PS - 1) / `DPO_CLK_PERIOD_PS)
`define DPO_SYNC_TMO_CYC    1048576
`define DPO_WORD_W          20
`define DPO_VID_W           18
`define DPO_CTL_W           9
`define DPO_GRP_W           6
`define DPO_VID_LSB         2
`define DPO_CTL_VOTE_LSB    1
`define DPO_CTL_DIRECT_LSB  16
`define DPO_RANGE_SLOW      2'h2
`define DPO_RANGE_FAST      2'h3
`define DPO_PCLK_DIV_W      3
`define DPO_PCLK_DIV        3'h3
`endif

// file: inc/dpo_pkg.sv
// types for the parallel output stage
package dpo_pkg;
  typedef enum logic [1:0] {DPO_SEARCH, DPO_LOCKED} dpo_state_t;
  typedef enum logic {DPO_EDGE_SLOW, DPO_EDGE_FAST} dpo_edge_t;
endpackage : dpo_pkg

// file: sim/dpo_output_stage_properties.sv
// port checker for the parallel output stage
`timescale 1ns/100ps
module dpo_output_stage_chk (
  input wire logic        clk_i,
  input wire logic        rstn_i,
  input wire logic        word_valid_i,
  input wire logic [19:0] word_i,
  input wire logic        word_is_video_i,
  input wire logic [1:0]  freq_range_sel_i,
  input wire logic [17:0] video_out_o,
  input wire logic [17:0] video_out_oe_o,
  input wire logic [8:0]  control_out_o,
  input wire logic [8:0]  control_out_oe_o,
  input wire logic        video_phase_flag_o,
  input wire logic        video_phase_flag_oe_o,
  input wire logic        not_synced_o,
  input wire logic        fast_edge_o
);
  logic tk;
  assign tk = word_valid_i && !not_synced_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  function automatic logic [8:0] vote(input logic [19:0] w);
    logic [2:0] t;
    vote[8:5] = w[19:16];
    for (int i = 0; i < 5; i++) begin
      t = w[3*i+1 +: 3];
      vote[i] = (t[0] & t[1]) | (t[0] & t[2]) | (t[1] & t[2]);
    end
  endfunction : vote
  a_oe_grouped: assert property (
    video_out_oe_o == {18{video_phase_flag_oe_o}}
    && control_out_oe_o == {9{video_phase_flag_oe_o}}) else $error("oe split");
  a_edge_fast: assert property (
    (freq_range_sel_i == 2'h3)[*4] |-> fast_edge_o) else $error("not fast");
  a_edge_slow: assert property (
    (freq_range_sel_i == 2'h2)[*4] |-> !fast_edge_o) else $error("not slow");
  a_flag_phase: assert property (
    tk |=> video_phase_flag_o == $past(word_is_video_i)) else $error("flag");
  a_ctl_vote: assert property (
    tk && !word_is_video_i |=> control_out_o == vote($past(word_i)))
    else $error("ctl decode");
  a_ctl_hold: assert property (
    !not_synced_o && !(word_valid_i && !word_is_video_i)
    |=> not_synced_o || $stable(control_out_o)) else $error("ctl moved");
  a_grp_first: assert property (
    tk && word_is_video_i |-> ##2 (not_synced_o
    || video_out_o[5:0] == $past(word_i[7:2], 2))) else $error("grp0");
  a_grp_last: assert property (
    tk && word_is_video_i |-> ##4 (not_synced_o
    || video_out_o[17:12] == $past(word_i[19:14], 4))) else $error("grp2");
  a_unlocked_low: assert property (
    not_synced_o[*2] |-> video_out_o == 18'h0 && control_out_o == 9'h0
    && !video_phase_flag_o) else $error("not low");
  c_video: cover property (tk && word_is_video_i);
  c_ctl: cover property (tk && !word_is_video_i);
  c_lock: cover property ($fell(not_synced_o));
endmodule : dpo_output_stage_chk
bind dpo_output_stage dpo_output_stage_chk u_chk (.*);

// file: sim/dpo_word_src.sv
// upstream word source standing in for the remote link
`timescale 1ns/100ps
module dpo_word_src (
  output logic        word_valid_o,
  output logic [19:0] word_o,
  output logic        word_is_video_o,
  output logic        transition_word_o,
  output logic        input_active_o,
  input  wire logic   clk_i
);
  initial begin
    word_valid_o = 1'b0;
    word_o = 20'h0;
    word_is_video_o = 1'b0;
    transition_word_o = 1'b0;
    input_active_o = 1'b0;
  end
  function automatic logic [19:0] cw(input logic [8:0] c);
    cw = {c[8:5], {3{c[4]}}, {3{c[3]}}, {3{c[2]}}, {3{c[1]}}, {3{c[0]}}, 1'b1};
  endfunction : cw
  task automatic send(input logic vid, input logic [19:0] w);
    @(negedge clk_i);
    word_valid_o = 1'b1;
    word_is_video_o = vid;
    word_o = w;
  endtask : send
  // idle word lines toggle so stale data never looks valid
  task automatic idle;
    @(negedge clk_i);
    word_valid_o = 1'b0;
    word_o = ~word_o;
  endtask : idle
  task automatic link(input logic up);
    @(negedge clk_i);
    input_active_o = up;
    transition_word_o = up;
    @(negedge clk_i);
    transition_word_o = 1'b0;
  endtask : link
endmodule : dpo_word_src

// file: sim/test_deser_parallel_output_stage.sv
// self-checking bench for the parallel output stage
`timescale 1ns/100ps
module test_deser_parallel_output_stage;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic outputs_on_i = 1'b1;
  logic latch_edge_select_i = 1'b1;
  logic local_reference_clock_i = 1'b0;
  logic [1:0] freq_range_sel_i = 2'h2;
  logic word_valid_i, word_is_video_i, transition_word_i, input_active_i;
  logic [19:0] word_i;
  logic [17:0] video_out_o, video_out_oe_o;
  logic [8:0] control_out_o, control_out_oe_o;
  logic video_phase_flag_o, video_phase_flag_oe_o, recovered_clock_out_o;
  logic recovered_clock_out_oe_o, not_synced_o, not_synced_oe_o, fast_edge_o;
  logic [8:0] cs [4] = '{9'h1a5, 9'h05a, 9'h1ff, 9'h100};
  int error_cnt = 0;
  int n_tests = 0;
  dpo_output_stage DUT (.*);
  dpo_word_src src (.clk_i, .word_valid_o(word_valid_i), .word_o(word_i),
    .word_is_video_o(word_is_video_i), .transition_word_o(transition_word_i),
    .input_active_o(input_active_i));
  initial forever #2.5 clk_i = ~clk_i;
  initial forever #17 local_reference_clock_i = ~local_reference_clock_i;
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask : cyc
  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : results
  // bounded wait for the sync flag
  task automatic wait_ns(input logic lvl);
    for (int i = 0; i < 40 && not_synced_o !== lvl; i++) cyc(1);
    chk(not_synced_o, lvl);
    if (not_synced_o !== lvl)
      results();
  endtask : wait_ns
  initial begin
    cyc(2);
    rstn_i = 1'b1;
    cyc(4);
    src.send(1'b1, 20'hfffff);
    src.idle();
    cyc(5);
    chk(not_synced_o, 1'b1);
    chk(video_out_o, 18'h0);
    $display("test idle done");
    src.link(1'b1);
    wait_ns(1'b0);
    src.send(1'b1, {18'h2aaaa, 2'h1});
    src.send(1'b1, {18'h3f0c3, 2'h2});
    src.idle();
    chk(recovered_clock_out_o, 1'b0);
    cyc(6);
    chk(recovered_clock_out_o, 1'b1);
    chk(video_out_o, 18'h3f0c3);
    chk(video_phase_flag_o, 1'b1);
    chk(control_out_o, 9'h0);
    $display("test video done");
    latch_edge_select_i = 1'b0;
    // one flipped bit in every triple must be voted out
    foreach (cs[i]) begin
      src.send(1'b0, src.cw(cs[i]) ^ 20'h02492);
      src.idle();
      cyc(3);
      chk(control_out_o, cs[i]);
      chk(video_out_o, 18'h3f0c3);
      chk(video_phase_flag_o, 1'b0);
    end
    src.send(1'b1, 20'h55554);
    src.idle();
    chk(recovered_clock_out_o, 1'b1);
    cyc(6);
    chk(recovered_clock_out_o, 1'b0);
    chk(video_out_o, 18'h15555);
    chk(control_out_o, 9'h100);
    $display("test control done");
    freq_range_sel_i = 2'h3;
    cyc(6);
    chk(fast_edge_o, 1'b1);
    freq_range_sel_i = 2'h2;
    cyc(6);
    chk(fast_edge_o, 1'b0);
    outputs_on_i = 1'b0;
    cyc(7);
    chk({video_out_oe_o, not_synced_oe_o, recovered_clock_out_oe_o},
        20'h0);
    outputs_on_i = 1'b1;
    cyc(4);
    chk({video_out_oe_o, not_synced_oe_o, recovered_clock_out_oe_o},
        20'hfffff);
    $display("test pins done");
    src.link(1'b0);
    wait_ns(1'b1);
    cyc(3);
    chk(video_out_o, 18'h0);
    chk(control_out_o, 9'h0);
    $display("test loss done");
    results();
  end
endmodule : test_deser_parallel_output_stage

// file: verilog/dpo_output_stage.sv
// parallel output stage of the serial video link receiver
`timescale 1ns/100ps
`include "dpo_defines.svh"
module dpo_output_stage
  import dpo_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        word_valid_i,
  input  wire logic [19:0] word_i,
  input  wire logic        word_is_video_i,
  input  wire logic        transition_word_i,
  input  wire logic        input_active_i,
  input  wire logic        local_reference_clock_i,
  input  wire logic        outputs_on_i,
  input  wire logic        latch_edge_select_i,
  input  wire logic [1:0]  freq_range_sel_i,
  output logic      [17:0] video_out_o,
  output logic      [17:0] video_out_oe_o,
  output logic      [8:0]  control_out_o,
  output logic      [8:0]  control_out_oe_o,
  output logic             video_phase_flag_o,
  output logic             video_phase_flag_oe_o,
  output logic             recovered_clock_out_o,
  output logic             recovered_clock_out_oe_o,
  output logic             not_synced_o,
  output logic             not_synced_oe_o,
  output logic             fast_edge_o
);

  // ******************************************
  // pin synchronisers
  // ******************************************
  logic [4:0] pins_s;
  dpo_sync2 #(.W(5)) u_sync (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .d_i    ({outputs_on_i, latch_edge_select_i, freq_range_sel_i,
              local_reference_clock_i}),
    .q_o    (pins_s)
  );
  logic       oen_s;
  logic       edge_rise_s;
  logic [1:0] range_s;
  logic       ref_clk_s;
  assign oen_s       = pins_s[4];
  assign edge_rise_s = pins_s[3];
  assign range_s     = pins_s[2:1];
  assign ref_clk_s   = pins_s[0];

  // ******************************************
  // sync search and timeout
  // ******************************************
  dpo_state_t state_reg;
  logic [20:0] tmo_reg;
  logic        tmo_hit;
  assign tmo_hit = (tmo_reg == 21'(`DPO_SYNC_TMO_CYC - 1));

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= DPO_SEARCH;
    end else if (!input_active_i) begin
      state_reg <= DPO_SEARCH;
    end else if (transition_word_i) begin
      state_reg <= DPO_LOCKED;
    end else if (tmo_hit) begin
      state_reg <= DPO_SEARCH;
    end
  end

  // restarts on every transition word; search keeps going after a timeout
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tmo_reg <= '0;
    end else if (transition_word_i || tmo_hit || !input_active_i) begin
      tmo_reg <= '0;
    end else begin
      tmo_reg <= tmo_reg + 21'h1;
    end
  end

  logic locked;
  assign locked = (state_reg == DPO_LOCKED);

  // ******************************************
  // word decode
  // ******************************************
  logic [8:0] ctl_dec;
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      ctl_dec[i] = (word_i[1+3*i] & word_i[2+3*i]) |
                   (word_i[1+3*i] & word_i[3+3*i]) |
                   (word_i[2+3*i] & word_i[3+3*i]);
    end
    ctl_dec[8:5] = word_i[19:16];
  end

  // ******************************************
  // output registers
  // ******************************************
  logic [17:0] vid_reg;
  logic [8:0]  ctl_reg;
  logic        de_reg;
  logic        vid_upd_reg;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      vid_reg     <= '0;
      ctl_reg     <= '0;
      de_reg      <= 1'b0;
      vid_upd_reg <= 1'b0;
    end else if (!locked) begin
      vid_reg     <= '0;
      ctl_reg     <= '0;
      de_reg      <= 1'b0;
      vid_upd_reg <= 1'b0;
    end else begin
      vid_upd_reg <= word_valid_i && word_is_video_i;
      if (word_valid_i) begin
        de_reg <= word_is_video_i;
        if (word_is_video_i) begin
          vid_reg <= word_i[19:2];
        end else begin
          ctl_reg <= ctl_dec;
        end
      end
    end
  end

  // ******************************************
  // staggered video groups
  // ******************************************
  // one clock is the smallest step here, so the nominal 1ns becomes 5ns
  logic [17:0] vid_out_reg;
  logic [5:0]  vid_mid_reg;
  logic [5:0]  vid_hi_d1_reg;
  logic [5:0]  vid_hi_reg;

  // unlock clears the whole pipe at once so no late group lingers high
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      vid_mid_reg   <= '0;
      vid_hi_d1_reg <= '0;
      vid_hi_reg    <= '0;
    end else if (!locked) begin
      vid_mid_reg   <= '0;
      vid_hi_d1_reg <= '0;
      vid_hi_reg    <= '0;
    end else begin
      vid_mid_reg   <= vid_reg[11:6];
      vid_hi_d1_reg <= vid_reg[17:12];
      vid_hi_reg    <= vid_hi_d1_reg;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      vid_out_reg <= '0;
    end else if (!locked) begin
      vid_out_reg <= '0;
    end else begin
      vid_out_reg[5:0]   <= vid_reg[5:0];
      vid_out_reg[11:6]  <= vid_mid_reg;
      vid_out_reg[17:12] <= vid_hi_reg;
    end
  end

  // ******************************************
  // parallel clock out
  // ******************************************
  // clk_i is not forwardable, so the word clock is a divided copy
  logic [2:0] div_reg;
  logic       pclk_reg;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_reg  <= '0;
      pclk_reg <= 1'b0;
    end else if (word_valid_i) begin
      div_reg  <= '0;
      pclk_reg <= ~edge_rise_s;
    end else if (div_reg == `DPO_PCLK_DIV) begin
      pclk_reg <= edge_rise_s;
      div_reg  <= div_reg;
    end else begin
      div_reg  <= div_reg + 3'h1;
    end
  end

  always_comb begin
    recovered_clock_out_o = locked ? pclk_reg : ref_clk_s;
  end

  // ******************************************
  // pins and enables
  // ******************************************
  assign video_out_o        = vid_out_reg;
  assign control_out_o      = ctl_reg;
  assign video_phase_flag_o = de_reg;
  assign not_synced_o       = ~locked;
  assign fast_edge_o        = (range_s == `DPO_RANGE_FAST);

  assign video_out_oe_o           = {18{oen_s}};
  assign control_out_oe_o         = {9{oen_s}};
  assign video_phase_flag_oe_o    = oen_s;
  assign recovered_clock_out_oe_o = oen_s;
  assign not_synced_oe_o          = oen_s;

endmodule : dpo_output_stage

// file: verilog/dpo_sync2.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module dpo_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_reg <= '0;
      q_o      <= '0;
    end else begin
      meta_reg <= d_i;
      q_o      <= meta_reg;
    end
  end
endmodule : dpo_sync2
